// *** jts_tap_dev.sv ***
// Test access port device: controller, chains, access handshake, pin switch
`timescale 1ns/1ps
`include "jts_regs.svh"
module jts_tap_dev
	import jts_pkg::*;
#(
	parameter logic [31:0] ID_VALUE = `JTS_ID_DEFAULT // Arbitrary identity
)(
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             txn_req,
	output logic      [34:0] txn_data,
	input  wire logic        txn_done,
	input  wire logic [31:0] txn_rdata,
	output logic      [4:0]  alt_function_select,
	output logic      [4:0]  pad_pull_up_enable,
	output logic             swd_active,
	jts_link_if.target       link
);

	// ****************************************
	// State and reset value
	// ****************************************
	localparam jts_dev_st_t DEV_RST = '{
		default  : '0,
		tap      : JTS_TLR,
		ir       : `JTS_IR_IDCODE,
		tdo_oe_n : 1'h1,
		pre_ok   : 1'h1,
		afsel    : `JTS_AFSEL_RST,
		pur      : `JTS_PUR_RST
	};

	jts_dev_st_t s_r;
	jts_dev_st_t s_nxt;
	logic        rise;
	logic        fall;
	logic        active;
	jts_chain_t  sel;
	jts_tap_t    nt;

	// ****************************************
	// Controller next state
	// ****************************************
	// Standard diagram; the TMS-high arcs lead every state home in five steps
	function automatic jts_tap_t tap_step(jts_tap_t st, logic tms);
		jts_tap_t n;
		n = st;
		case (st)
			JTS_TLR:  n = tms ? JTS_TLR  : JTS_RTI;
			JTS_RTI:  n = tms ? JTS_SDR  : JTS_RTI;
			JTS_SDR:  n = tms ? JTS_SIR  : JTS_CDR;
			JTS_CDR:  n = tms ? JTS_E1DR : JTS_SHDR;
			JTS_SHDR: n = tms ? JTS_E1DR : JTS_SHDR;
			JTS_E1DR: n = tms ? JTS_UDR  : JTS_PDR;
			JTS_PDR:  n = tms ? JTS_E2DR : JTS_PDR;
			JTS_E2DR: n = tms ? JTS_UDR  : JTS_SHDR;
			JTS_UDR:  n = tms ? JTS_SDR  : JTS_RTI;
			JTS_SIR:  n = tms ? JTS_TLR  : JTS_CIR;
			JTS_CIR:  n = tms ? JTS_E1IR : JTS_SHIR;
			JTS_SHIR: n = tms ? JTS_E1IR : JTS_SHIR;
			JTS_E1IR: n = tms ? JTS_UIR  : JTS_PIR;
			JTS_PIR:  n = tms ? JTS_E2IR : JTS_PIR;
			JTS_E2IR: n = tms ? JTS_UIR  : JTS_SHIR;
			JTS_UIR:  n = tms ? JTS_SDR  : JTS_RTI;
			default:  n = JTS_TLR;
		endcase
		return n;
	endfunction

	// Instruction decode; every code without its own chain falls to bypass
	function automatic jts_chain_t chain_of(logic [3:0] ir);
		jts_chain_t c;
		c = JTS_CH_BYP;
		case (ir)
			`JTS_IR_IDCODE: c = JTS_CH_IDC;
			`JTS_IR_DPACC:  c = JTS_CH_ACC;
			`JTS_IR_APACC:  c = JTS_CH_ACC;
			`JTS_IR_ABORT:  c = JTS_CH_ABT;
			default:        c = JTS_CH_BYP;
		endcase
		return c;
	endfunction

	// ****************************************
	// Edge finding on the synchronised test clock
	// ****************************************
	// Only the second stage and its delayed copy are looked at
	assign rise   = s_r.tck_s[1] & ~s_r.tck_d;
	assign fall   = ~s_r.tck_s[1] & s_r.tck_d;
	assign active = (&s_r.afsel) & ~s_r.swd;
	assign sel    = chain_of(s_r.ir);
	assign nt     = tap_step(s_r.tap, s_r.tms_s[1]);

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		s_nxt         = s_r;
		s_nxt.txn_req = 1'h0;
		s_nxt.ack     = 1'h0;
		s_nxt.tck_s   = {s_r.tck_s[0], link.tck};
		s_nxt.tms_s   = {s_r.tms_s[0], link.tms};
		s_nxt.tdi_s   = {s_r.tdi_s[0], link.tdi};
		s_nxt.trst_s  = {s_r.trst_s[0], link.trst_n};
		s_nxt.tck_d   = s_r.tck_s[1];

		// Completion from the system side ends the pending access
		if (txn_done)
		begin
			s_nxt.busy  = 1'h0;
			s_nxt.rdata = txn_rdata;
		end

		// Test reset held low pins the controller; inputs sampled on rise
		if (!s_r.trst_s[1])
		begin
			s_nxt.tap    = JTS_TLR;
			s_nxt.ir     = `JTS_IR_IDCODE;
			s_nxt.pre_ok = 1'h1;
			s_nxt.pass   = '0;
		end
		else if (active && rise)
		begin
			case (s_r.tap)
				JTS_TLR:
				begin
					s_nxt.ir     = `JTS_IR_IDCODE;
					s_nxt.pre_ok = 1'h1;
					s_nxt.pass   = '0;
				end
				JTS_CIR:
					s_nxt.ir_sh = `JTS_IR_CAPT;
				JTS_SHIR:
				begin
					s_nxt.ir_sh  = {s_r.tdi_s[1], s_r.ir_sh[3:1]};
					s_nxt.pre_ok = 1'h0;
				end
				JTS_UIR:
				begin
					s_nxt.ir = s_r.ir_sh;
					if (s_r.pass != `JTS_PASS_MAX)
						s_nxt.pass = s_r.pass + 2'h1;
				end
				JTS_CDR:
				begin
					s_nxt.pre_ok = 1'h0;
					case (sel)
						JTS_CH_IDC: s_nxt.dr_sh = {3'h0, ID_VALUE};
						JTS_CH_ACC: s_nxt.dr_sh = {s_r.rdata, s_r.busy ? `JTS_ACK_WAIT : `JTS_ACK_OK};
						default:    s_nxt.dr_sh = '0;
					endcase
				end
				JTS_SHDR:
				begin
					s_nxt.pre_ok = 1'h0;
					s_nxt.dr_sh  = s_r.dr_sh >> 1;
					case (sel)
						JTS_CH_BYP: s_nxt.dr_sh[`JTS_BYP_MSB] = s_r.tdi_s[1];
						JTS_CH_IDC: s_nxt.dr_sh[`JTS_IDC_MSB] = s_r.tdi_s[1];
						default:    s_nxt.dr_sh[`JTS_ACC_MSB] = s_r.tdi_s[1];
					endcase
				end
				JTS_UDR:
				begin
					s_nxt.pre_ok = 1'h0;
					// A busy port drops the new access; the debugger sees WAIT next time
					if (sel == JTS_CH_ACC && !s_r.busy)
					begin
						s_nxt.txn_req  = 1'h1;
						s_nxt.busy     = 1'h1;
						s_nxt.txn_data = s_r.dr_sh;
					end
					else if (sel == JTS_CH_ABT)
						s_nxt.busy = 1'h0;
				end
				JTS_RTI, JTS_SDR, JTS_SIR, JTS_E1IR:
					s_nxt.pre_ok = s_r.pre_ok;
				default:
					s_nxt.pre_ok = 1'h0;
			endcase

			// Second empty load then back to reset switches to serial-wire
			if (s_r.tap == JTS_SIR && nt == JTS_TLR && s_r.pre_ok && s_r.pass == `JTS_PRE_PASSES)
				s_nxt.swd = 1'h1;
			s_nxt.tap = nt;
		end

		// Output side moves on the falling edge, but test reset or inactive pins release it at once
		if (!active || !s_r.trst_s[1])
			s_nxt.tdo_oe_n = 1'h1;
		else if (fall)
		begin
			case (s_r.tap)
				JTS_SHIR:
				begin
					s_nxt.tdo      = s_r.ir_sh[0];
					s_nxt.tdo_oe_n = 1'h0;
				end
				JTS_SHDR:
				begin
					s_nxt.tdo      = s_r.dr_sh[0];
					s_nxt.tdo_oe_n = 1'h0;
				end
				default:
					s_nxt.tdo_oe_n = 1'h1;
			endcase
		end

		// Register bus slave, one wait state, unmapped reads zero
		if (wb_cyc_i && wb_stb_i && !s_r.ack)
		begin
			s_nxt.ack = 1'h1;
			s_nxt.dat = '0;
			case (wb_adr_i)
				`JTS_DEV_AFSEL:
				begin
					s_nxt.dat[4:0] = s_r.afsel;
					if (wb_we_i && wb_sel_i[0])
						s_nxt.afsel = wb_dat_i[4:0];
				end
				`JTS_DEV_PUR:
				begin
					s_nxt.dat[4:0] = s_r.pur;
					if (wb_we_i && wb_sel_i[0])
						s_nxt.pur = wb_dat_i[4:0];
				end
				`JTS_DEV_STAT:
				begin
					s_nxt.dat[`JTS_ST_SWD]                    = s_r.swd;
					s_nxt.dat[`JTS_ST_BUSY]                   = s_r.busy;
					s_nxt.dat[`JTS_ST_TAP_HI:`JTS_ST_TAP_LO]  = s_r.tap;
				end
				default:
					s_nxt.dat = '0;
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	// Reset brings the pins up in test function with pull-ups on
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			s_r <= DEV_RST;
		else if (ce)
			s_r <= s_nxt;
	end

	// Outputs straight from the state register
	assign wb_dat_o            = s_r.dat;
	assign wb_ack_o            = s_r.ack;
	assign txn_req             = s_r.txn_req;
	assign txn_data            = s_r.txn_data;
	assign alt_function_select = s_r.afsel;
	assign pad_pull_up_enable  = s_r.pur;
	assign swd_active          = s_r.swd;
	assign link.tdo            = s_r.tdo;
	assign link.tdo_oe_n       = s_r.tdo_oe_n;

endmodule

// *** jts_regs.svh ***
// Constants for the test access port, its serial chains and both register maps
`ifndef JTS_REGS_SVH
`define JTS_REGS_SVH

// Instruction codes
`define JTS_IR_EXTEST   4'h0
`define JTS_IR_INTEST   4'h1
`define JTS_IR_SAMPLE   4'h2
`define JTS_IR_ABORT    4'h8
`define JTS_IR_DPACC    4'hA
`define JTS_IR_APACC    4'hB
`define JTS_IR_IDCODE   4'hE
`define JTS_IR_BYPASS   4'hF
`define JTS_IR_CAPT     4'h1

// Identity value, arbitrary neutral pattern
`define JTS_ID_DEFAULT  32'h1000_0001

// Acknowledge codes and chain top bits
`define JTS_ACK_OK      3'h2
`define JTS_ACK_WAIT    3'h1
`define JTS_BYP_MSB     0
`define JTS_IDC_MSB     31
`define JTS_ACC_MSB     34
`define JTS_PRE_PASSES  2'h2
`define JTS_PASS_MAX    2'h3

// Device register map and reset values
`define JTS_DEV_AFSEL   8'h00
`define JTS_DEV_PUR     8'h04
`define JTS_DEV_STAT    8'h08
`define JTS_AFSEL_RST   5'h1F
`define JTS_PUR_RST     5'h1F
`define JTS_ST_SWD      0
`define JTS_ST_BUSY     1
`define JTS_ST_TAP_LO   4
`define JTS_ST_TAP_HI   7

// Probe register map and fields
`define JTS_HOST_CMD    8'h00
`define JTS_HOST_STAT   8'h04
`define JTS_HOST_CAPT   8'h08
`define JTS_CMD_TMS     0
`define JTS_CMD_TDI     1
`define JTS_CMD_TRST    2
`define JTS_HST_BUSY    0
`define JTS_HST_TDO     1
`define JTS_TCK_HALF    4'h8

`endif

// *** jts_pkg.sv ***
// Types shared by the test port device and the probe
package jts_pkg;

	// Controller states
	typedef enum logic [3:0] {
		JTS_TLR  = 4'h0, JTS_RTI  = 4'h1, JTS_SDR  = 4'h2, JTS_CDR  = 4'h3,
		JTS_SHDR = 4'h4, JTS_E1DR = 4'h5, JTS_PDR  = 4'h6, JTS_E2DR = 4'h7,
		JTS_UDR  = 4'h8, JTS_SIR  = 4'h9, JTS_CIR  = 4'hA, JTS_SHIR = 4'hB,
		JTS_E1IR = 4'hC, JTS_PIR  = 4'hD, JTS_E2IR = 4'hE, JTS_UIR  = 4'hF
	} jts_tap_t;

	// Selected data chain
	typedef enum logic [1:0] {
		JTS_CH_BYP = 2'h0, JTS_CH_IDC = 2'h1, JTS_CH_ACC = 2'h2, JTS_CH_ABT = 2'h3
	} jts_chain_t;

	// Whole state of the device end
	typedef struct packed {
		logic [1:0]  tck_s;
		logic [1:0]  tms_s;
		logic [1:0]  tdi_s;
		logic [1:0]  trst_s;
		logic        tck_d;
		jts_tap_t    tap;
		logic [3:0]  ir_sh;
		logic [3:0]  ir;
		logic [34:0] dr_sh;
		logic        tdo;
		logic        tdo_oe_n;
		logic        pre_ok;
		logic [1:0]  pass;
		logic        swd;
		logic [4:0]  afsel;
		logic [4:0]  pur;
		logic        ack;
		logic [31:0] dat;
		logic        txn_req;
		logic        busy;
		logic [34:0] txn_data;
		logic [31:0] rdata;
	} jts_dev_st_t;

	// Whole state of the probe end
	typedef struct packed {
		logic        tck;
		logic        tms;
		logic        tdi;
		logic        trst_n;
		logic        busy;
		logic [3:0]  cnt;
		logic [1:0]  tdo_s;
		logic [31:0] capt;
		logic        ack;
		logic [31:0] dat;
	} jts_host_st_t;

endpackage

// *** jts_link_if.sv ***
// Five-wire test link between probe and device, with the pulled output wire
`timescale 1ns/1ps
interface jts_link_if;
	logic tck;
	logic tms;
	logic tdi;
	logic trst_n;
	logic tdo;
	logic tdo_oe_n;
	logic tdo_pin;

	// Pull-up holds the wire high while the device releases it
	assign tdo_pin = tdo_oe_n ? 1'h1 : tdo;

	modport probe
	(
		output tck, tms, tdi, trst_n,
		input  tdo_pin
	);
	modport target
	(
		input  tck, tms, tdi, trst_n,
		output tdo, tdo_oe_n
	);
endinterface

// *** jts_probe.sv ***
// Probe end: makes the test clock, drives the pins one cycle per command
`timescale 1ns/1ps
`include "jts_regs.svh"
module jts_probe
	import jts_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	jts_link_if.probe        link
);

	// ****************************************
	// State and reset value
	// ****************************************
	localparam jts_host_st_t HOST_RST = '{
		default : '0,
		tms     : 1'h1,
		tdi     : 1'h1,
		trst_n  : 1'h1
	};

	jts_host_st_t s_r;
	jts_host_st_t s_nxt;

	// ****************************************
	// Next state
	// ****************************************
	// Clock idles low; pins change only while it is low
	always_comb
	begin
		s_nxt       = s_r;
		s_nxt.ack   = 1'h0;
		s_nxt.tdo_s = {s_r.tdo_s[0], link.tdo_pin};

		// One test clock cycle: low half, then high half, then back low
		if (s_r.busy)
		begin
			if (s_r.cnt == `JTS_TCK_HALF - 4'h1)
			begin
				s_nxt.cnt = '0;
				if (!s_r.tck)
				begin
					s_nxt.tck  = 1'h1;
					s_nxt.capt = {s_r.tdo_s[1], s_r.capt[31:1]};
				end
				else
				begin
					s_nxt.tck  = 1'h0;
					s_nxt.busy = 1'h0;
				end
			end
			else
				s_nxt.cnt = s_r.cnt + 4'h1;
		end

		// Register bus slave; a command while busy is dropped
		if (wb_cyc_i && wb_stb_i && !s_r.ack)
		begin
			s_nxt.ack = 1'h1;
			s_nxt.dat = '0;
			case (wb_adr_i)
				`JTS_HOST_CMD:
				begin
					s_nxt.dat[`JTS_CMD_TMS]  = s_r.tms;
					s_nxt.dat[`JTS_CMD_TDI]  = s_r.tdi;
					s_nxt.dat[`JTS_CMD_TRST] = ~s_r.trst_n;
					if (wb_we_i && wb_sel_i[0] && !s_r.busy)
					begin
						s_nxt.tms    = wb_dat_i[`JTS_CMD_TMS];
						s_nxt.tdi    = wb_dat_i[`JTS_CMD_TDI];
						s_nxt.trst_n = ~wb_dat_i[`JTS_CMD_TRST];
						s_nxt.busy   = 1'h1;
						s_nxt.cnt    = '0;
					end
				end
				`JTS_HOST_STAT:
				begin
					s_nxt.dat[`JTS_HST_BUSY] = s_r.busy;
					s_nxt.dat[`JTS_HST_TDO]  = s_r.capt[31];
				end
				`JTS_HOST_CAPT:
					s_nxt.dat = s_r.capt;
				default:
					s_nxt.dat = '0;
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			s_r <= HOST_RST;
		else if (ce)
			s_r <= s_nxt;
	end

	// Outputs straight from the state register
	assign wb_dat_o    = s_r.dat;
	assign wb_ack_o    = s_r.ack;
	assign link.tck    = s_r.tck;
	assign link.tms    = s_r.tms;
	assign link.tdi    = s_r.tdi;
	assign link.trst_n = s_r.trst_n;

endmodule

// *** jts_link_sva.sv ***
// Timing checks on the five-wire test link between probe and device
`timescale 1ns/1ps
module jts_link_sva
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	input wire logic tdo,
	input wire logic tdo_oe_n,
	input wire logic tdo_pin
);
	// ****************************************
	// Link properties, all in the system clock domain
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	// A driven output may only move while the test clock has been low a while
	property p_tdo_on_fall;
		$changed(tdo) && !tdo_oe_n |-> !tck && !$past(tck);
	endproperty
	a_tdo_on_fall: assert property (p_tdo_on_fall)
		else $error("tdo moved near a test clock rise");

	property p_drive_after_fall;
		$fell(tdo_oe_n) |-> !tck && !$past(tck);
	endproperty
	a_drive_after_fall: assert property (p_drive_after_fall)
		else $error("output driver enabled outside the low clock phase");

	property p_release_low;
		$rose(tdo_oe_n) |-> !tck;
	endproperty
	a_release_low: assert property (p_release_low)
		else $error("output released while test clock high");

	// Probe side keeps inputs still across the sampling rise
	property p_inputs_on_fall;
		$changed(tms) || $changed(tdi) |-> !tck && !$past(tck);
	endproperty
	a_inputs_on_fall: assert property (p_inputs_on_fall)
		else $error("mode or data input moved near a clock rise");

	property p_tck_high;
		$rose(tck) |-> tck [*8] ##1 !tck;
	endproperty
	a_tck_high: assert property (p_tck_high)
		else $error("test clock high phase not eight cycles");

	property p_tck_low;
		$fell(tck) |-> !tck [*8];
	endproperty
	a_tck_low: assert property (p_tck_low)
		else $error("test clock low phase under eight cycles");

	// Synchroniser plus register: four cycles of test reset must free the pin
	property p_trst_release;
		!trst_n [*4] |-> tdo_oe_n && tdo_pin;
	endproperty
	a_trst_release: assert property (p_trst_release)
		else $error("output still driven during test reset");

	property p_trst_on_low;
		$changed(trst_n) |-> !tck && !$past(tck);
	endproperty
	a_trst_on_low: assert property (p_trst_on_low)
		else $error("test reset moved near a clock rise");
endmodule

// *** jts_tap_with_swd_switch_tb.sv ***
// Bench joining probe and device over the test link, driven through both register buses
`timescale 1ns/1ps
`include "jts_regs.svh"
module jts_tap_with_swd_switch_tb;
	localparam logic [31:0] TB_ID = 32'h5A3C_0F81; // Arbitrary identity pattern
	logic        ref_clk, arst_n, txn_done, txn_req, swd_active;
	logic        m_dv, m_we, m_stb, p_ack, d_ack, ack;
	logic [7:0]  m_adr;
	logic [31:0] m_dat, p_q, d_q, rq, txn_rdata;
	logic [34:0] txn_data, td;
	logic [4:0]  afs, pur;
	int          fails, num_checks, n_req;

	// ****************************************
	// Structure
	// ****************************************
	jts_link_if lnk();
	assign ack = m_dv ? d_ack : p_ack;
	assign rq = m_dv ? d_q : p_q;
	jts_tap_dev #(.ID_VALUE(TB_ID)) jts_tap_dev_i
	(
		.ref_clk(ref_clk), .arst_n(arst_n), .ce(1'b1), .wb_cyc_i(m_stb & m_dv), .wb_stb_i(m_stb & m_dv),
		.wb_we_i(m_we), .wb_adr_i(m_adr), .wb_sel_i(4'h1), .wb_dat_i(m_dat), .wb_dat_o(d_q), .wb_ack_o(d_ack),
		.txn_req(txn_req), .txn_data(txn_data), .txn_done(txn_done), .txn_rdata(txn_rdata),
		.alt_function_select(afs), .pad_pull_up_enable(pur), .swd_active(swd_active), .link(lnk)
	);
	jts_probe jts_probe_i
	(
		.ref_clk(ref_clk), .arst_n(arst_n), .ce(1'b1), .wb_cyc_i(m_stb & !m_dv), .wb_stb_i(m_stb & !m_dv),
		.wb_we_i(m_we), .wb_adr_i(m_adr), .wb_sel_i(4'h1), .wb_dat_i(m_dat), .wb_dat_o(p_q), .wb_ack_o(p_ack),
		.link(lnk)
	);
	jts_link_sva chk_i
	(
		.ref_clk(ref_clk), .arst_n(arst_n), .tck(lnk.tck), .tms(lnk.tms), .tdi(lnk.tdi), .trst_n(lnk.trst_n),
		.tdo(lnk.tdo), .tdo_oe_n(lnk.tdo_oe_n), .tdo_pin(lnk.tdo_pin)
	);

	// Free-running system clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Access requests are one-cycle pulses, so they are caught here
	// Only this process writes the request count, so reset clears it here
	always @(posedge ref_clk)
		if (!arst_n)
			n_req <= 0;
		else if (txn_req === 1'b1)
		begin
			n_req <= n_req + 1;
			td <= txn_data;
		end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Classic single cycle; the wait for acknowledge is bounded
	task automatic wb(input bit dv, input bit we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge ref_clk);
		m_dv <= dv;
		m_we <= we;
		m_adr <= a;
		m_dat <= d;
		m_stb <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge ref_clk);
			if (ack === 1'b1)
				break;
		end
		q = rq;
		m_stb <= 1'b0;
		if (n >= 40)
		begin
			fails++;
			give_verdict();
		end
	endtask

	// One test clock cycle; busy polling keeps commands spaced as the probe needs
	task automatic step(input bit tms, input bit tdi, input bit rst = 1'b0);
		logic [31:0] q;
		int n;
		wb(0, 1, `JTS_HOST_CMD, {29'h0, rst, tdi, tms}, q);
		for (n = 0; n < 20; n++)
		begin
			wb(0, 0, `JTS_HOST_STAT, 32'h0, q);
			if (q[`JTS_HST_BUSY] === 1'b0)
				break;
		end
		if (n >= 20)
		begin
			fails++;
			give_verdict();
		end
		repeat (4) @(posedge ref_clk);
	endtask

	// Full scan from idle or reset, LSB first; c3 holds the first three samples
	task automatic shift(input bit ir, input int n, input logic [34:0] d, output logic [31:0] c3, output logic [31:0] c);
		int i;
		step(0, 0);
		step(1, 0);
		if (ir)
			step(1, 0);
		step(0, 0);
		step(0, 0);
		for (i = 0; i < n; i++)
		begin
			step(i == n - 1, d[i]);
			if (i == 2)
				wb(0, 0, `JTS_HOST_CAPT, 32'h0, c3);
		end
		wb(0, 0, `JTS_HOST_CAPT, 32'h0, c);
		step(1, 0);
		step(0, 0);
	endtask

	task automatic walk(input logic [16:0] s, input int n);
		int i;
		for (i = 0; i < n; i++)
			step(s[i], 1);
	endtask

	task automatic tap_is(input logic [3:0] st);
		logic [31:0] q;
		wb(1, 0, `JTS_DEV_STAT, 32'h0, q);
		chk(q[7:4], st);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		logic [31:0] q;
		wb(1, 0, `JTS_DEV_AFSEL, 32'h0, q);
		chk(q, 35'h1F);
		wb(1, 0, `JTS_DEV_PUR, 32'h0, q);
		chk(q, 35'h1F);
		wb(1, 0, `JTS_DEV_STAT, 32'h0, q);
		chk(q, 35'h0);
		chk(swd_active, 1'b0);
		chk(afs, 5'h1F);
		chk(pur, 5'h1F);
		wb(1, 0, 8'h40, 32'h0, q);
		chk(q, 35'h0);
		$display("test reset done");
	endtask

	task automatic t_chains();
		logic [31:0] c3, c;
		logic [3:0]  codes [3] = '{4'hF, 4'h3, 4'h0};
		shift(0, 32, 35'h0, c3, c);
		chk(c, TB_ID);
		foreach (codes[k])
		begin
			shift(1, 4, {31'h0, codes[k]}, c3, c);
			chk(c[31:28], `JTS_IR_CAPT);
			shift(0, 8, 35'hB4, c3, c);
			chk(c[31:24], 8'h68);
		end
		$display("test chains done");
	endtask

	// Second access is refused while the first is open, then acknowledge turns OK
	task automatic t_access();
		logic [31:0] c3, c;
		shift(1, 4, 35'hA, c3, c);
		shift(0, 35, 35'h1_2345_6782, c3, c);
		chk(n_req, 1);
		chk(td, 35'h1_2345_6782);
		shift(0, 35, 35'h0_0000_0001, c3, c);
		chk(c3[31:29], `JTS_ACK_WAIT);
		chk(n_req, 1);
		@(posedge ref_clk);
		txn_rdata <= 32'hC0DE_5AB7;
		txn_done <= 1'b1;
		@(posedge ref_clk);
		txn_done <= 1'b0;
		shift(0, 35, 35'h4_0000_0005, c3, c);
		chk(c3[31:29], `JTS_ACK_OK);
		chk(c, 32'hC0DE_5AB7);
		chk(td, 35'h4_0000_0005);
		chk(n_req, 2);
		// Abort frees the port with the access still open; the other access code then runs
		shift(1, 4, {31'h0, `JTS_IR_ABORT}, c3, c);
		shift(0, 35, 35'h0, c3, c);
		shift(1, 4, {31'h0, `JTS_IR_APACC}, c3, c);
		shift(0, 35, 35'h2_4680_ACE3, c3, c);
		chk(c3[31:29], `JTS_ACK_OK);
		chk(c, 32'hC0DE_5AB7);
		chk(n_req, 3);
		chk(td, 35'h2_4680_ACE3);
		$display("test access done");
	endtask

	task automatic t_resets();
		logic [31:0] c3, c;
		shift(1, 4, 35'hF, c3, c);
		step(1, 0);
		step(0, 0);
		step(0, 0);
		tap_is(jts_pkg::JTS_SHDR);
		repeat (5) step(1, 0);
		tap_is(jts_pkg::JTS_TLR);
		shift(0, 32, 35'h0, c3, c);
		chk(c, TB_ID);
		shift(1, 4, 35'hF, c3, c);
		step(0, 0, 1);
		tap_is(jts_pkg::JTS_TLR);
		shift(0, 32, 35'h0, c3, c);
		chk(c, TB_ID);
		$display("test resets done");
	endtask

	// Pins handed to general use ignore the clock until reclaimed
	task automatic t_pins();
		logic [31:0] q;
		wb(1, 1, `JTS_DEV_AFSEL, 32'h0, q);
		wb(1, 0, `JTS_DEV_AFSEL, 32'h0, q);
		chk(q, 35'h0);
		chk(afs, 5'h00);
		chk(lnk.tdo_oe_n, 1'b1);
		step(1, 0);
		tap_is(jts_pkg::JTS_RTI);
		wb(1, 1, `JTS_DEV_PUR, 32'h0, q);
		wb(1, 1, `JTS_DEV_PUR, 32'h1F, q);
		wb(1, 1, `JTS_DEV_AFSEL, 32'h1F, q);
		wb(1, 0, `JTS_DEV_PUR, 32'h0, q);
		chk(q, 35'h1F);
		chk(afs, 5'h1F);
		chk(pur, 5'h1F);
		step(1, 0);
		tap_is(jts_pkg::JTS_SDR);
		step(1, 0);
		step(1, 0);
		$display("test pins done");
	endtask

	task automatic t_swd();
		logic [31:0] q;
		walk(17'h1_DB66, 17);
		wb(1, 0, `JTS_DEV_STAT, 32'h0, q);
		chk(q[`JTS_ST_SWD], 1'b0);
		walk(17'h0_EDB6, 16);
		wb(1, 0, `JTS_DEV_STAT, 32'h0, q);
		chk(q[`JTS_ST_SWD], 1'b1);
		chk(swd_active, 1'b1);
		$display("test switch done");
	endtask

	// Main sequence, with a second reset after the mode switch
	initial
	begin
		{m_dv, m_we, m_stb, txn_done, arst_n} = 5'h0;
		{m_adr, m_dat, txn_rdata} = 72'h0;
		{fails, num_checks} = 64'h0;
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_reset();
		t_chains();
		t_access();
		t_resets();
		t_pins();
		t_swd();
		arst_n <= 1'b0;
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_reset();
		give_verdict();
	end
endmodule
